// File: core/nfc_convert.sv
/*
 * Normalized fixed-point to/from single precision float converter, one register stage.
 * Assumes the requester always supplies the signed equation select with each request.
 */
`timescale 1ns/100ps

// What this block does
// - b is the per-instance integer width used by every equation.
// - unsigned to float gives c over two to the b minus one.
// - signed to float, full method: (2c+1) over two to the b minus one.
// - signed to float, symmetric method: c over 2^(b-1)-1, at least -1.0.
// - symmetric method maps the most negative code to exactly -1.0.
// - float to unsigned: clamp to [0,1], scale by 2^b-1, cast b bits.
// - float to signed, query method: clamp, then (f*(2^b-1)-1)/2.
// - float to signed, symmetric method: clamp, then f*(2^(b-1)-1).
// - signed results are cast to b-bit two's complement.
module nfc_convert #(
	parameter int BITS = nfc_pkg::NFC_B_BITS
) (
	input  wire logic             mclk_in,     // 50 MHz clock
	input  wire logic             rst_b_in,    // synchronous reset, active low
	input  wire logic             req_vld_in,  // conversion request, one cycle
	input  wire nfc_pkg::nfc_op_t op_in,       // conversion kind
	input  wire nfc_pkg::nfc_eq_t eq_in,       // signed equation select
	input  wire logic [BITS-1:0]  int_in,      // fixed-point operand
	input  wire logic [31:0]      flt_in,      // float operand
	output logic                  res_vld_out, // result valid, one cycle
	output logic [31:0]           flt_out,     // float result
	output logic [BITS-1:0]       int_out      // fixed-point result
);

	localparam int W     = BITS + nfc_pkg::NFC_Q_EXTRA;
	localparam int QW    = W + 1;
	localparam int NWD   = BITS + 1 + W;
	localparam int FRAC  = nfc_pkg::NFC_FX_FRAC;
	localparam int FXW   = FRAC + 1;
	localparam int PW    = FRAC + BITS + 2;
	localparam int MB    = nfc_pkg::NFC_MANT_BITS;
	localparam int EXP_SHIFT = int'(nfc_pkg::NFC_EXP_BIAS) + MB;
	localparam logic [BITS:0]     D_FULL   = {1'b0, {BITS{1'b1}}};
	localparam logic [BITS:0]     D_SYM    = {2'b00, {(BITS-1){1'b1}}};
	localparam logic [BITS-1:0]   I_MIN_S  = {1'b1, {(BITS-1){1'b0}}};
	localparam logic [BITS-1:0]   I_MAX_S  = {1'b0, {(BITS-1){1'b1}}};
	localparam logic [FXW-1:0]    FX_ONE   = {1'b1, {FRAC{1'b0}}};
	localparam logic [PW-1:0]     RND_HALF = PW'(1) << (FRAC - 1);
	localparam logic [PW-1:0]     RND_CEIL = (PW'(1) << (FRAC + 1)) - PW'(1);

	typedef struct packed {
		logic            vld;
		logic [31:0]     flt;
		logic [BITS-1:0] ival;
	} nfc_state_t;

	nfc_state_t      state_r;
	nfc_state_t      state_nxt;

	logic [BITS:0]   num_mag;
	logic            num_neg;
	logic [BITS:0]   den;
	logic [BITS:0]   odd_val;
	logic [NWD-1:0]  numer;
	logic [NWD-1:0]  quo;
	logic [QW-1:0]   norm;
	int              lead;
	logic [MB-1:0]   mant_raw;
	logic            rnd_bit;
	logic            sticky;
	logic            mant_inc;
	logic [MB:0]     mant_sum;
	logic [7:0]      exp_val;
	logic [31:0]     flt_res;

	logic            f_sign;
	logic [7:0]      f_exp;
	logic            f_nan;
	logic [MB:0]     f_sig;
	logic [FXW-1:0]  fx;
	logic [PW-1:0]   p_full;
	logic [PW-1:0]   p_sym;
	logic [PW-1:0]   r_full;
	logic [PW-1:0]   r_sym;
	logic [PW-1:0]   r_half;
	logic [BITS-1:0] u_int;
	logic [BITS-1:0] s_full_int;
	logic [BITS-1:0] s_sym_int;

	function automatic int lead_one_pos(input logic [QW-1:0] v);
		int pos;
		pos = 0;
		for (int i = 0; i < QW; i++) begin
			if (v[i]) begin
				pos = i;
			end
		end
		return pos;
	endfunction : lead_one_pos

	// integer to float: exact quotient, then normalize and round
	always_comb begin
		num_mag = {1'b0, int_in};
		num_neg = 1'b0;
		den     = D_FULL;
		odd_val = {int_in, 1'b1};
		if (op_in == nfc_pkg::NFC_OP_S2F) begin
			if (eq_in == nfc_pkg::NFC_EQ_FULL) begin
				num_neg = int_in[BITS-1];
				num_mag = num_neg ? (~odd_val + 1'b1) : odd_val;
			end else begin
				den     = D_SYM;
				num_neg = int_in[BITS-1];
				if (int_in == I_MIN_S) begin
					num_mag = D_SYM;
				end else if (num_neg) begin
					num_mag = {1'b0, ~int_in + 1'b1};
				end
			end
		end
		numer    = {num_mag, {W{1'b0}}};
		quo      = numer / {{W{1'b0}}, den};
		lead     = lead_one_pos(quo[QW-1:0]);
		norm     = quo[QW-1:0] << (QW - 1 - lead);
		mant_raw = norm[QW-2 -: MB];
		rnd_bit  = norm[QW-2-MB];
		// odd divisor: the dropped remainder is zero only at zero or at full scale
		sticky   = (|norm[QW-3-MB:0]) | ((num_mag != '0) & (num_mag != den));
		mant_inc = rnd_bit & (sticky | mant_raw[0]);
		mant_sum = {1'b0, mant_raw} + {{MB{1'b0}}, mant_inc};
		exp_val  = 8'(int'(nfc_pkg::NFC_EXP_BIAS) + lead - W + int'(mant_sum[MB]));
		flt_res  = (num_mag == '0) ? nfc_pkg::NFC_FLT_ZERO
			: {num_neg, exp_val, mant_sum[MB-1:0]};
	end

	// float to integer: clamp magnitude into fixed point, scale, round
	always_comb begin
		f_sign = flt_in[31];
		f_exp  = flt_in[30:23];
		f_nan  = (f_exp == nfc_pkg::NFC_EXP_SPECIAL) && (flt_in[MB-1:0] != '0);
		f_sig  = {1'b1, flt_in[MB-1:0]};
		if (f_nan || (f_exp == 8'h00)) begin
			fx = '0;
		end else if (f_exp >= nfc_pkg::NFC_EXP_BIAS) begin
			fx = FX_ONE;
		end else begin
			fx = FXW'({f_sig, {FRAC{1'b0}}} >> (EXP_SHIFT - int'(f_exp)));
		end
		p_full = PW'(fx) * PW'(D_FULL);
		p_sym  = PW'(fx) * PW'(D_SYM);
		r_full = (p_full + RND_HALF) >> FRAC;
		r_sym  = (p_sym + RND_HALF) >> FRAC;
		u_int  = (f_sign && (fx != '0)) ? '0 : r_full[BITS-1:0];
		// floor of (f*(2^b-1)-1)/2 plus one half
		if (f_sign) begin
			r_half     = (p_full + RND_CEIL) >> (FRAC + 1);
			s_full_int = ~r_half[BITS-1:0] + 1'b1;
		end else begin
			r_half     = p_full >> (FRAC + 1);
			s_full_int = r_half[BITS-1:0];
		end
		s_sym_int = f_sign ? (~r_sym[BITS-1:0] + 1'b1) : r_sym[BITS-1:0];
	end

	// result register: the field that the request does not produce reads zero
	always_comb begin
		state_nxt     = state_r;
		state_nxt.vld = req_vld_in;
		if (req_vld_in) begin
			unique case (op_in)
				nfc_pkg::NFC_OP_U2F,
				nfc_pkg::NFC_OP_S2F: begin
					state_nxt.flt  = flt_res;
					state_nxt.ival = '0;
				end
				nfc_pkg::NFC_OP_F2U: begin
					state_nxt.flt  = nfc_pkg::NFC_FLT_ZERO;
					state_nxt.ival = u_int;
				end
				nfc_pkg::NFC_OP_F2S: begin
					state_nxt.flt  = nfc_pkg::NFC_FLT_ZERO;
					state_nxt.ival = (eq_in == nfc_pkg::NFC_EQ_FULL) ? s_full_int : s_sym_int;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign res_vld_out = state_r.vld;
	assign flt_out     = state_r.flt;
	assign int_out     = state_r.ival;

	default clocking cb_main @(posedge mclk_in);
	endclocking
	default disable iff (!rst_b_in);

	sequence s_req(nfc_pkg::nfc_op_t op, nfc_pkg::nfc_eq_t eq);
		req_vld_in && (op_in == op) && (eq_in == eq);
	endsequence

	sequence s_result_flt(logic [31:0] v);
		res_vld_out && (flt_out == v) && (int_out == '0);
	endsequence

	a_result_latency: assert property (req_vld_in |=> res_vld_out ##1 !res_vld_out || $past(req_vld_in))
		else $error("result valid not one cycle after request");
	a_unorm_ends: assert property (req_vld_in && (op_in == nfc_pkg::NFC_OP_U2F) && (int_in == '1) |=> s_result_flt(nfc_pkg::NFC_FLT_POS_ONE))
		else $error("all-ones unsigned code did not give 1.0");
	a_unorm_zero: assert property (req_vld_in && (op_in == nfc_pkg::NFC_OP_U2F) && (int_in == '0) |=> s_result_flt(nfc_pkg::NFC_FLT_ZERO))
		else $error("zero unsigned code did not give 0.0");
	a_full_min: assert property (s_req(nfc_pkg::NFC_OP_S2F, nfc_pkg::NFC_EQ_FULL) ##0 (int_in == I_MIN_S) |=> s_result_flt(nfc_pkg::NFC_FLT_NEG_ONE))
		else $error("full method lowest code did not give -1.0");
	a_full_no_zero: assert property (s_req(nfc_pkg::NFC_OP_S2F, nfc_pkg::NFC_EQ_FULL) |=> res_vld_out && (flt_out[30:0] != '0))
		else $error("full method produced an exact zero");
	a_sym_max: assert property (s_req(nfc_pkg::NFC_OP_S2F, nfc_pkg::NFC_EQ_SYM) ##0 (int_in == I_MAX_S) |=> s_result_flt(nfc_pkg::NFC_FLT_POS_ONE))
		else $error("symmetric method top code did not give 1.0");
	a_sym_clamp: assert property (s_req(nfc_pkg::NFC_OP_S2F, nfc_pkg::NFC_EQ_SYM) ##0 (int_in == I_MIN_S) |=> s_result_flt(nfc_pkg::NFC_FLT_NEG_ONE))
		else $error("symmetric method lowest code not clamped to -1.0");
	a_f2u_clamp: assert property (req_vld_in && (op_in == nfc_pkg::NFC_OP_F2U) && flt_in[31] |=> res_vld_out && (int_out == '0))
		else $error("negative float did not give unsigned zero");
	a_f2u_half: assert property (req_vld_in && (op_in == nfc_pkg::NFC_OP_F2U) && (flt_in == nfc_pkg::NFC_FLT_HALF) |=> int_out == {1'b1, {(BITS-1){1'b0}}})
		else $error("0.5 did not round to nearest");
	a_f2s_query: assert property (s_req(nfc_pkg::NFC_OP_F2S, nfc_pkg::NFC_EQ_FULL) ##0 (flt_in == nfc_pkg::NFC_FLT_NEG_ONE) |=> (int_out == I_MIN_S) && (flt_out == '0))
		else $error("query method -1.0 did not give lowest code");
	a_f2s_sym: assert property (s_req(nfc_pkg::NFC_OP_F2S, nfc_pkg::NFC_EQ_SYM) ##0 (flt_in == nfc_pkg::NFC_FLT_NEG_ONE) |=> int_out == (I_MIN_S + 1'b1))
		else $error("symmetric method -1.0 did not give -(2^(b-1)-1)");
	a_f2s_top: assert property (req_vld_in && (op_in == nfc_pkg::NFC_OP_F2S) && (flt_in == nfc_pkg::NFC_FLT_POS_ONE) |=> int_out == I_MAX_S)
		else $error("1.0 did not give the top signed code");

endmodule : nfc_convert

// File: core/nfc_pkg.sv
/*
 * Shared constants and types for the normalized fixed/float converter.
 * Assumes single precision floats in the usual sign/exponent/mantissa layout.
 */
package nfc_pkg;

	// default width b of the fixed-point operand
	localparam int          NFC_B_BITS      = 16;
	// fraction bits of the clamped float magnitude on the float-to-int path
	localparam int          NFC_FX_FRAC     = 30;
	// quotient bits kept beyond b on the int-to-float path
	localparam int          NFC_Q_EXTRA     = 25;
	localparam int          NFC_MANT_BITS   = 23;
	localparam logic [7:0]  NFC_EXP_BIAS    = 8'h7F;
	localparam logic [7:0]  NFC_EXP_SPECIAL = 8'hFF;
	localparam logic [31:0] NFC_FLT_ZERO    = 32'h0000_0000;
	localparam logic [31:0] NFC_FLT_POS_ONE = 32'h3F80_0000;
	localparam logic [31:0] NFC_FLT_NEG_ONE = 32'hBF80_0000;
	localparam logic [31:0] NFC_FLT_HALF    = 32'h3F00_0000;

	// direction and signedness of one conversion
	typedef enum logic [1:0] {
		NFC_OP_U2F,
		NFC_OP_S2F,
		NFC_OP_F2U,
		NFC_OP_F2S
	} nfc_op_t;

	// full: vertex parameters and state queries; sym: texture and framebuffer
	typedef enum logic {
		NFC_EQ_FULL,
		NFC_EQ_SYM
	} nfc_eq_t;

endpackage : nfc_pkg

// File: dv/nfc_src_model.sv
/*
 * Operand source model: stands in for the pipeline stage that feeds the converter.
 * Assumes one rising-edge clock; the caller waits out reset before issuing.
 */
`timescale 1ns/100ps

module nfc_src_model #(
	parameter int BITS = nfc_pkg::NFC_B_BITS
) (
	input  wire logic             mclk_in,     // converter clock
	output nfc_pkg::nfc_op_t      op_out,      // conversion kind
	output nfc_pkg::nfc_eq_t      eq_out,      // signed equation select
	output logic                  req_vld_out, // request strobe
	output logic [BITS-1:0]       int_out,     // fixed-point operand
	output logic [31:0]           flt_out      // float operand
);
	initial begin
		req_vld_out = 1'b0;
		op_out      = nfc_pkg::NFC_OP_U2F;
		eq_out      = nfc_pkg::NFC_EQ_FULL;
		int_out     = '0;
		flt_out     = 32'h0000_0000;
	end

	task automatic issue(input nfc_pkg::nfc_op_t op, input nfc_pkg::nfc_eq_t eq,
		input logic [BITS-1:0] iv, input logic [31:0] fv);
		@(posedge mclk_in);
		req_vld_out <= 1'b1;
		op_out      <= op;
		eq_out      <= eq;
		int_out     <= iv;
		flt_out     <= fv;
		@(posedge mclk_in);
		// operands are stale once taken, so show their inverse
		req_vld_out <= 1'b0;
		int_out     <= ~iv;
		flt_out     <= ~fv;
	endtask : issue
endmodule : nfc_src_model

// File: dv/normalized_fixed_float_convert_tb.sv
/*
 * Self-checking bench for the converter at eight-bit width.
 * Assumes the source model drives every request and a 50 MHz clock.
 */
`timescale 1ns/100ps

module normalized_fixed_float_convert_tb;
	localparam int BITS = 8;
	logic             mclk_in = 1'b0;
	logic             rst_b_in = 1'b0;
	logic             req_vld;
	nfc_pkg::nfc_op_t op;
	nfc_pkg::nfc_eq_t eq;
	logic [BITS-1:0]  int_opnd;
	logic [31:0]      flt_opnd;
	logic             res_vld_out;
	logic [31:0]      flt_out;
	logic [BITS-1:0]  int_out;
	int               errors = 0;
	int               comparisons = 0;

	always #10 mclk_in = ~mclk_in;

	nfc_src_model #(.BITS(BITS)) i_nfc_src_model (.mclk_in(mclk_in), .op_out(op),
		.eq_out(eq), .req_vld_out(req_vld), .int_out(int_opnd), .flt_out(flt_opnd));

	nfc_convert #(.BITS(BITS)) i_nfc_convert (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
		.req_vld_in(req_vld), .op_in(op), .eq_in(eq), .int_in(int_opnd),
		.flt_in(flt_opnd), .res_vld_out(res_vld_out), .flt_out(flt_out),
		.int_out(int_out));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one request, result one cycle later, then a quiet cycle that holds it
	task automatic conv(input nfc_pkg::nfc_op_t o, input nfc_pkg::nfc_eq_t e,
		input logic [BITS-1:0] iv, input logic [31:0] fv,
		input logic [31:0] ef, input logic [BITS-1:0] ei);
		i_nfc_src_model.issue(o, e, iv, fv);
		#1;
		chk({31'h0, res_vld_out}, 32'h0000_0001);
		chk(flt_out, ef);
		chk({24'h0, int_out}, {24'h0, ei});
		@(posedge mclk_in);
		#1;
		chk({31'h0, res_vld_out}, 32'h0000_0000);
		chk(flt_out, ef);
		chk({24'h0, int_out}, {24'h0, ei});
	endtask : conv

	task automatic test_u2f();
		conv(nfc_pkg::NFC_OP_U2F, nfc_pkg::NFC_EQ_FULL, 8'hFF, 32'h0, 32'h3F80_0000, 8'h00);
		conv(nfc_pkg::NFC_OP_U2F, nfc_pkg::NFC_EQ_FULL, 8'h80, 32'h0, 32'h3F00_8081, 8'h00);
		conv(nfc_pkg::NFC_OP_U2F, nfc_pkg::NFC_EQ_SYM, 8'h00, 32'h0, 32'h0000_0000, 8'h00);
	endtask : test_u2f

	task automatic test_s2f();
		conv(nfc_pkg::NFC_OP_S2F, nfc_pkg::NFC_EQ_FULL, 8'h80, 32'h0, 32'hBF80_0000, 8'h00);
		conv(nfc_pkg::NFC_OP_S2F, nfc_pkg::NFC_EQ_FULL, 8'h7F, 32'h0, 32'h3F80_0000, 8'h00);
		conv(nfc_pkg::NFC_OP_S2F, nfc_pkg::NFC_EQ_SYM, 8'h81, 32'h0, 32'hBF80_0000, 8'h00);
		conv(nfc_pkg::NFC_OP_S2F, nfc_pkg::NFC_EQ_SYM, 8'h80, 32'h0, 32'hBF80_0000, 8'h00);
		conv(nfc_pkg::NFC_OP_S2F, nfc_pkg::NFC_EQ_SYM, 8'h00, 32'h0, 32'h0000_0000, 8'h00);
		conv(nfc_pkg::NFC_OP_S2F, nfc_pkg::NFC_EQ_SYM, 8'h7F, 32'h0, 32'h3F80_0000, 8'h00);
		conv(nfc_pkg::NFC_OP_S2F, nfc_pkg::NFC_EQ_FULL, 8'h00, 32'h0, 32'h3B80_8081, 8'h00);
		conv(nfc_pkg::NFC_OP_S2F, nfc_pkg::NFC_EQ_FULL, 8'hFF, 32'h0, 32'hBB80_8081, 8'h00);
	endtask : test_s2f

	task automatic test_f2u();
		conv(nfc_pkg::NFC_OP_F2U, nfc_pkg::NFC_EQ_FULL, 8'h0, 32'h3F80_0000, 32'h0, 8'hFF);
		conv(nfc_pkg::NFC_OP_F2U, nfc_pkg::NFC_EQ_FULL, 8'h0, 32'hBF80_0000, 32'h0, 8'h00);
		conv(nfc_pkg::NFC_OP_F2U, nfc_pkg::NFC_EQ_FULL, 8'h0, 32'h4000_0000, 32'h0, 8'hFF);
		conv(nfc_pkg::NFC_OP_F2U, nfc_pkg::NFC_EQ_FULL, 8'h0, 32'h3F00_0000, 32'h0, 8'h80);
		conv(nfc_pkg::NFC_OP_F2U, nfc_pkg::NFC_EQ_FULL, 8'h0, 32'h3E80_0000, 32'h0, 8'h40);
	endtask : test_f2u

	task automatic test_f2s();
		conv(nfc_pkg::NFC_OP_F2S, nfc_pkg::NFC_EQ_FULL, 8'h0, 32'hBF80_0000, 32'h0, 8'h80);
		conv(nfc_pkg::NFC_OP_F2S, nfc_pkg::NFC_EQ_FULL, 8'h0, 32'h4000_0000, 32'h0, 8'h7F);
		conv(nfc_pkg::NFC_OP_F2S, nfc_pkg::NFC_EQ_SYM, 8'h0, 32'hBF80_0000, 32'h0, 8'h81);
		conv(nfc_pkg::NFC_OP_F2S, nfc_pkg::NFC_EQ_SYM, 8'h0, 32'h3F80_0000, 32'h0, 8'h7F);
		conv(nfc_pkg::NFC_OP_F2S, nfc_pkg::NFC_EQ_SYM, 8'h0, 32'hBF00_0000, 32'h0, 8'hC0);
		conv(nfc_pkg::NFC_OP_F2S, nfc_pkg::NFC_EQ_FULL, 8'h0, 32'h3F00_0000, 32'h0, 8'h3F);
	endtask : test_f2s

	task automatic end_of_test();
		if (errors == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test

	initial begin
		repeat (16) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		#1;
		chk({31'h0, res_vld_out}, 32'h0000_0000);
		test_u2f();
		test_s2f();
		test_f2u();
		test_f2s();
		end_of_test();
	end

	// the sequence needs about 80 cycles
	initial begin
		#100us;
		errors++;
		end_of_test();
	end
endmodule : normalized_fixed_float_convert_tb
